// file: pkg/quasi_port_pkg.sv
// Shared constants for the quasi-bidirectional port block
package quasi_port_pkg;
  localparam int PORT_W        = 8;
  localparam int HIGH_W        = 2;
  localparam int PORT_COUNT    = 4;
  localparam int PIN_TOTAL     = HIGH_W + 3 * PORT_W;
  // Indices into the per-port write strobes
  localparam int IDX_PORT2     = 0;
  localparam int IDX_PORT3     = 1;
  localparam int IDX_PORT4     = 2;
  localparam int IDX_PORT5     = 3;
  // Offsets of each port in the combined pin vector
  localparam int OFS_PORT2     = 0;
  localparam int OFS_PORT3     = OFS_PORT2 + HIGH_W;
  localparam int OFS_PORT4     = OFS_PORT3 + PORT_W;
  localparam int OFS_PORT5     = OFS_PORT4 + PORT_W;
  // Port 2 upper bits as placed in the high lane
  localparam int P2_ADDR14     = 0;
  localparam int P2_ADDR15     = 1;
  // Port 3 bit positions
  localparam int P3_SER_RX     = 0;
  localparam int P3_SER_TX     = 1;
  localparam int P3_IRQ0       = 2;
  localparam int P3_IRQ1       = 3;
  localparam int P3_TMR0       = 4;
  localparam int P3_TMR1_CLK   = 5;
  localparam int P3_WR_STB     = 6;
  localparam int P3_RD_STB     = 7;
  // Port 4 split between chip selects and address bits
  localparam int P4_SEL_COUNT  = 4;
  localparam int P4_ADDR_BASE  = 4;
  // Port 5 bit positions
  localparam int P5_CAN_TX     = 0;
  localparam int P5_CAN_RX     = 1;
  localparam int P5_TMR3       = 2;
  // Address bits 19..14 carried on the ports
  localparam int ADDR_HI_W     = 6;
  localparam int ADDR_A14      = 0;
  localparam int ADDR_A15      = 1;
  localparam int ADDR_A16      = 2;
  // Reset values
  localparam logic [PORT_W-1:0] LATCH_RESET = 8'hff;
  localparam logic              PIN_IDLE    = 1'b1;
  // Strong high driver timing
  localparam int CLOCK_PERIOD_NS   = 10;
  localparam int HIGH_DRIVE_NS     = 20;
  localparam int HIGH_DRIVE_CYCLES =
    (HIGH_DRIVE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int PULSE_W           = 2;
  localparam logic [PULSE_W-1:0] PULSE_LOAD = PULSE_W'(HIGH_DRIVE_CYCLES - 1);
endpackage

// file: pkg/quasi_lane_if.sv
// Control and drive signals of one quasi-bidirectional lane
`timescale 1ns/100ps
interface quasi_lane_if #(parameter int W = 8);
  logic         wrEn;
  logic [W-1:0] wrData;
  logic [W-1:0] altEn;
  logic [W-1:0] altVal;
  logic [W-1:0] latch;
  logic [W-1:0] drvOut;
  logic [W-1:0] drvOe;
  logic [W-1:0] weakUp;

  modport ctrl (output wrEn, wrData, altEn, altVal, input latch, drvOut, drvOe, weakUp);
  modport lane (input wrEn, wrData, altEn, altVal, output latch, drvOut, drvOe, weakUp);
endinterface

// file: verilog/pin_input_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module pin_input_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic         clockEnable,
  // Pins and filtered result
  input  wire logic [W-1:0] pinRaw,
  output logic      [W-1:0] pinClean
);
  import quasi_port_pkg::*;

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;
  logic [W-1:0] next_pinClean;

  // Only stages two and three are compared; stage one may be metastable
  always_comb begin
    next_pinClean = pinClean;
    for (int i = 0; i < W; i++) begin
      if (stage2[i] == stage3[i]) begin
        next_pinClean[i] = stage3[i];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stage1   <= {W{PIN_IDLE}};
      stage2   <= {W{PIN_IDLE}};
      stage3   <= {W{PIN_IDLE}};
      pinClean <= {W{PIN_IDLE}};
    end else if (clockEnable) begin
      stage1   <= pinRaw;
      stage2   <= stage1;
      stage3   <= stage2;
      pinClean <= next_pinClean;
    end
  end
endmodule

// file: verilog/quasi_port_lane.sv
// Latches and pin drivers for one quasi-bidirectional port lane
`timescale 1ns/100ps
module quasi_port_lane #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic clockEnable,
  // Lane control and drive
  quasi_lane_if.lane lane
);
  import quasi_port_pkg::*;

  for (genvar b = 0; b < W; b++) begin : g_bit
    logic               bitLatch;
    logic               prevLevel;
    logic [PULSE_W-1:0] pulse;
    logic               next_bitLatch;
    logic               next_prevLevel;
    logic [PULSE_W-1:0] next_pulse;
    logic               level;
    logic               rise;

    always_comb begin
      next_bitLatch = bitLatch;
      if (lane.wrEn) begin
        next_bitLatch = lane.wrData[b];                       // see RQ3
      end
      level          = lane.altEn[b] ? lane.altVal[b] : bitLatch; // see RQ15
      rise           = level & ~prevLevel;
      next_prevLevel = level;
      // Short burst of strong drive on every 0 to 1 change, see RQ4
      if (rise) begin
        next_pulse = PULSE_LOAD;
      end else if (pulse != '0) begin
        next_pulse = pulse - PULSE_W'(1);
      end else begin
        next_pulse = '0;
      end
    end

    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        bitLatch  <= LATCH_RESET[0];                          // see RQ1
        prevLevel <= LATCH_RESET[0];
        pulse     <= '0;
      end else if (clockEnable) begin
        bitLatch  <= next_bitLatch;
        prevLevel <= next_prevLevel;
        pulse     <= next_pulse;
      end
    end

    // Low level: strong pull-down; high level: weak pull-up, plus strong drive during the burst after a rise, see RQ2 RQ3
    assign lane.latch[b]  = bitLatch;
    assign lane.drvOut[b] = level;
    assign lane.drvOe[b]  = ~level | rise | (pulse != '0);    // see RQ4
    assign lane.weakUp[b] = level;                            // see RQ2
  end
endmodule

// file: verilog/quasi_bidir_port_altfunc.sv
// Quasi-bidirectional ports 2 (upper bits), 3, 4 and 5 with alternate functions
// Summary of operation
// RQ1: Reset sets every port latch bit to one so each pin rests on its weak pull-up.
// RQ2: A pin whose latch is one acts as an input and its level is sampled.
// RQ3: Writing zero to a bit turns on a strong pull-down until a one is written or reset.
// RQ4: Writing one after zero gives a brief strong high drive, then only the weak pull-up.
// RQ5: Each port 4 pin is chosen as general I/O or memory signal by the function select.
// RQ6: Port 2 bits 6 and 7 carry address bits 14 and 15 during external memory access.
// RQ7: Port 3 bit 0 is serial 0 receive and bit 1 its transmit output when enabled.
// RQ8: Port 3 bits 2 and 3 are the inputs of external interrupts zero and one.
// RQ9: Port 3 bit 4 is the timer 0 count input; bit 5 is timer 1 input or clock output.
// RQ10: Port 3 bits 6 and 7 are the data write and read strobes during data accesses.
// RQ11: Port 4 bits 0 to 3, when selected, drive program chip selects 0 to 3.
// RQ12: Port 4 bits 4 to 7, when selected, drive address bits 16 to 19.
// RQ13: Port 5 bit 0 is the CAN transmit output and bit 1 its receive input, if CAN exists.
// RQ14: Port 5 bit 2 is the timer 3 input and bit 3 is general I/O only.
// RQ15: Output functions override the latch on their pin; input functions always sample it.
`timescale 1ns/100ps
module quasi_bidir_port_altfunc #(
  parameter bit CAN_PRESENT = 1'b1
) (
  // Clock and reset
  input  wire logic                                      clock,
  input  wire logic                                      rst_n,
  input  wire logic                                      clockEnable,
  // Port latch writes from the core
  input  wire logic [quasi_port_pkg::PORT_COUNT-1:0]     portWrite,
  input  wire logic [quasi_port_pkg::PORT_W-1:0]         writeData,
  input  wire logic [quasi_port_pkg::PORT_W-1:0]         port4FunctionSelect,
  // Memory interface functions
  input  wire logic                                      extMemAccess,
  input  wire logic                                      extDataAccess,
  input  wire logic [quasi_port_pkg::ADDR_HI_W-1:0]      memAddrHigh,
  input  wire logic [quasi_port_pkg::P4_SEL_COUNT-1:0]   programSelect,
  input  wire logic                                      dataWriteStrobe_n,
  input  wire logic                                      dataReadStrobe_n,
  // Peripheral output functions
  input  wire logic                                      serial0TxEnable,
  input  wire logic                                      serial0Transmit,
  input  wire logic                                      clockOutEnable,
  input  wire logic                                      clockOut,
  input  wire logic                                      canEnable,
  input  wire logic                                      canTransmitOut,
  // Peripheral input functions
  output logic                                           serial0Receive,
  output logic                                           externalIrqZero,
  output logic                                           externalIrqOne,
  output logic                                           timerZeroCountInput,
  output logic                                           timerOneInput,
  output logic                                           timerThreeExtInput,
  output logic                                           canReceiveIn,
  // Port 2 upper pins
  input  wire logic [quasi_port_pkg::HIGH_W-1:0]         port2PinIn,
  output logic      [quasi_port_pkg::HIGH_W-1:0]         port2PinOut,
  output logic      [quasi_port_pkg::HIGH_W-1:0]         port2PinOe,
  output logic      [quasi_port_pkg::HIGH_W-1:0]         port2WeakUp,
  // Port 3 pins
  input  wire logic [quasi_port_pkg::PORT_W-1:0]         port3PinIn,
  output logic      [quasi_port_pkg::PORT_W-1:0]         port3PinOut,
  output logic      [quasi_port_pkg::PORT_W-1:0]         port3PinOe,
  output logic      [quasi_port_pkg::PORT_W-1:0]         port3WeakUp,
  // Port 4 pins
  input  wire logic [quasi_port_pkg::PORT_W-1:0]         port4PinIn,
  output logic      [quasi_port_pkg::PORT_W-1:0]         port4PinOut,
  output logic      [quasi_port_pkg::PORT_W-1:0]         port4PinOe,
  output logic      [quasi_port_pkg::PORT_W-1:0]         port4WeakUp,
  // Port 5 pins
  input  wire logic [quasi_port_pkg::PORT_W-1:0]         port5PinIn,
  output logic      [quasi_port_pkg::PORT_W-1:0]         port5PinOut,
  output logic      [quasi_port_pkg::PORT_W-1:0]         port5PinOe,
  output logic      [quasi_port_pkg::PORT_W-1:0]         port5WeakUp,
  // Filtered pin levels for core reads
  output logic      [quasi_port_pkg::HIGH_W-1:0]         port2Pins,
  output logic      [quasi_port_pkg::PORT_W-1:0]         port3Pins,
  output logic      [quasi_port_pkg::PORT_W-1:0]         port4Pins,
  output logic      [quasi_port_pkg::PORT_W-1:0]         port5Pins,
  // Latch contents for read-modify-write
  output logic      [quasi_port_pkg::HIGH_W-1:0]         port2Latch,
  output logic      [quasi_port_pkg::PORT_W-1:0]         port3Latch,
  output logic      [quasi_port_pkg::PORT_W-1:0]         port4Latch,
  output logic      [quasi_port_pkg::PORT_W-1:0]         port5Latch
);
  import quasi_port_pkg::*;

  quasi_lane_if #(.W(HIGH_W)) lane2 ();
  quasi_lane_if #(.W(PORT_W)) lane3 ();
  quasi_lane_if #(.W(PORT_W)) lane4 ();
  quasi_lane_if #(.W(PORT_W)) lane5 ();

  logic [PIN_TOTAL-1:0] pinRaw;
  logic [PIN_TOTAL-1:0] pinClean;

  // Latch writes; port 2 only holds its two upper bits here
  always_comb begin
    lane2.wrEn   = portWrite[IDX_PORT2];
    lane2.wrData = writeData[PORT_W-1 -: HIGH_W];
    lane3.wrEn   = portWrite[IDX_PORT3];
    lane3.wrData = writeData;
    lane4.wrEn   = portWrite[IDX_PORT4];
    lane4.wrData = writeData;
    lane5.wrEn   = portWrite[IDX_PORT5];
    lane5.wrData = writeData;
  end

  // Port 2: upper address bits while external memory is being accessed
  always_comb begin
    lane2.altEn             = {HIGH_W{extMemAccess}};              // see RQ6
    lane2.altVal            = '0;
    lane2.altVal[P2_ADDR14] = memAddrHigh[ADDR_A14];               // see RQ6
    lane2.altVal[P2_ADDR15] = memAddrHigh[ADDR_A15];
  end

  // Port 3: serial, timer clock and data strobes; input functions need no enable
  always_comb begin
    lane3.altEn               = '0;
    lane3.altVal              = '1;
    lane3.altEn[P3_SER_TX]    = serial0TxEnable;                   // see RQ7
    lane3.altVal[P3_SER_TX]   = serial0Transmit;
    lane3.altEn[P3_TMR1_CLK]  = clockOutEnable;                    // see RQ9
    lane3.altVal[P3_TMR1_CLK] = clockOut;
    lane3.altEn[P3_WR_STB]    = extDataAccess;                     // see RQ10
    lane3.altVal[P3_WR_STB]   = dataWriteStrobe_n;
    lane3.altEn[P3_RD_STB]    = extDataAccess;
    lane3.altVal[P3_RD_STB]   = dataReadStrobe_n;
  end

  // Port 4: each bit picked individually by the function select
  always_comb begin
    lane4.altEn  = port4FunctionSelect;                            // see RQ5
    lane4.altVal = '1;
    for (int i = 0; i < P4_SEL_COUNT; i++) begin
      lane4.altVal[i] = programSelect[i];                          // see RQ11
      lane4.altVal[P4_ADDR_BASE + i] = memAddrHigh[ADDR_A16 + i]; // see RQ12
    end
  end

  // Port 5: CAN transmit only on the variant that has the controller
  always_comb begin
    lane5.altEn             = '0;
    lane5.altVal            = '1;
    lane5.altEn[P5_CAN_TX]  = CAN_PRESENT & canEnable;             // see RQ13
    lane5.altVal[P5_CAN_TX] = canTransmitOut;
  end

  quasi_port_lane #(.W(HIGH_W)) u_port2 (
    .clock       (clock),
    .rst_n       (rst_n),
    .clockEnable (clockEnable),
    .lane        (lane2)
  );

  quasi_port_lane #(.W(PORT_W)) u_port3 (
    .clock       (clock),
    .rst_n       (rst_n),
    .clockEnable (clockEnable),
    .lane        (lane3)
  );

  quasi_port_lane #(.W(PORT_W)) u_port4 (
    .clock       (clock),
    .rst_n       (rst_n),
    .clockEnable (clockEnable),
    .lane        (lane4)
  );

  quasi_port_lane #(.W(PORT_W)) u_port5 (
    .clock       (clock),
    .rst_n       (rst_n),
    .clockEnable (clockEnable),
    .lane        (lane5)
  );

  // Pin drive; the pad adds the weak pull-up when enable is low
  assign port2PinOut = lane2.drvOut;
  assign port2PinOe  = lane2.drvOe;
  assign port2WeakUp = lane2.weakUp;
  assign port3PinOut = lane3.drvOut;
  assign port3PinOe  = lane3.drvOe;
  assign port3WeakUp = lane3.weakUp;
  assign port4PinOut = lane4.drvOut;
  assign port4PinOe  = lane4.drvOe;
  assign port4WeakUp = lane4.weakUp;
  assign port5PinOut = lane5.drvOut;
  assign port5PinOe  = lane5.drvOe;
  assign port5WeakUp = lane5.weakUp;

  assign port2Latch = lane2.latch;
  assign port3Latch = lane3.latch;
  assign port4Latch = lane4.latch;
  assign port5Latch = lane5.latch;

  // All pins are sampled, whatever the latch holds
  assign pinRaw = {port5PinIn, port4PinIn, port3PinIn, port2PinIn};  // see RQ2 RQ15

  pin_input_sync #(.W(PIN_TOTAL)) u_sync (
    .clock       (clock),
    .rst_n       (rst_n),
    .clockEnable (clockEnable),
    .pinRaw      (pinRaw),
    .pinClean    (pinClean)
  );

  assign port2Pins = pinClean[OFS_PORT2 +: HIGH_W];
  assign port3Pins = pinClean[OFS_PORT3 +: PORT_W];
  assign port4Pins = pinClean[OFS_PORT4 +: PORT_W];
  assign port5Pins = pinClean[OFS_PORT5 +: PORT_W];

  // Input functions come straight from the filtered pins
  assign serial0Receive      = port3Pins[P3_SER_RX];                 // see RQ7
  assign externalIrqZero     = port3Pins[P3_IRQ0];                   // see RQ8
  assign externalIrqOne      = port3Pins[P3_IRQ1];                   // see RQ8
  assign timerZeroCountInput = port3Pins[P3_TMR0];                   // see RQ9
  assign timerOneInput       = port3Pins[P3_TMR1_CLK];               // see RQ9
  assign timerThreeExtInput  = port5Pins[P5_TMR3];                   // see RQ14
  // Without the controller the receive input idles recessive
  assign canReceiveIn = CAN_PRESENT ? port5Pins[P5_CAN_RX] : PIN_IDLE; // see RQ13
  // Port 5 bit 3 has no alternate function and stays plain I/O, see RQ14
endmodule

// file: tb/quasi_port_asserts.sv
// Concurrent checks on the quasi-bidirectional port block
`timescale 1ns/100ps
module quasi_port_asserts (
  // Clock and reset
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic       clockEnable,
  // Core and function controls
  input wire logic [3:0] portWrite,
  input wire logic [7:0] writeData,
  input wire logic [7:0] port4FunctionSelect,
  input wire logic       extMemAccess,
  input wire logic       extDataAccess,
  input wire logic [5:0] memAddrHigh,
  input wire logic [3:0] programSelect,
  input wire logic       dataWriteStrobe_n,
  input wire logic       dataReadStrobe_n,
  input wire logic       serial0TxEnable,
  input wire logic       serial0Transmit,
  input wire logic       canEnable,
  input wire logic       canTransmitOut,
  // Pin drive and sampled state
  input wire logic [1:0] port2PinOut,
  input wire logic [1:0] port2PinOe,
  input wire logic [1:0] port2WeakUp,
  input wire logic [7:0] port3PinIn,
  input wire logic [7:0] port3PinOut,
  input wire logic [7:0] port3PinOe,
  input wire logic [7:0] port3WeakUp,
  input wire logic [7:0] port3Pins,
  input wire logic [7:0] port4PinOut,
  input wire logic [7:0] port4PinOe,
  input wire logic [7:0] port4WeakUp,
  input wire logic [7:0] port4Latch,
  input wire logic [7:0] port5PinOut,
  input wire logic [7:0] port5PinOe,
  input wire logic [7:0] port5WeakUp,
  input wire logic [7:0] port5Latch
);
  // Level the device alone puts on each pin
  logic [1:0] lvl2;
  logic [7:0] lvl3, lvl4, lvl5;
  assign lvl2 = (port2PinOe & port2PinOut) | (~port2PinOe & port2WeakUp);
  assign lvl3 = (port3PinOe & port3PinOut) | (~port3PinOe & port3WeakUp);
  assign lvl4 = (port4PinOe & port4PinOut) | (~port4PinOe & port4WeakUp);
  assign lvl5 = (port5PinOe & port5PinOut) | (~port5PinOe & port5WeakUp);
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // Bit 3 of port 5 has no function, so its latch alone decides
  sequence raiseGpio;
    clockEnable && portWrite[3] && writeData[3] && !port5Latch[3];
  endsequence
  sequence quietGpio;
    clockEnable && !portWrite[3];
  endsequence
  chk_reset_latch: assert property ($rose(rst_n) |-> (port4Latch & port5Latch) == 8'hff)
    else $error("latch not all ones after reset");
  chk_zero_pull: assert property (clockEnable && portWrite[3] && !writeData[3]
    |=> port5PinOe[3] && !port5PinOut[3] && !port5WeakUp[3]) else $error("no pull-down");
  chk_burst_start: assert property (raiseGpio |=> (port5PinOe[3] && port5PinOut[3])
    ##1 port5PinOe[3]) else $error("strong high drive missing");
  chk_burst_end: assert property (raiseGpio ##1 quietGpio ##1 quietGpio
    |=> !port5PinOe[3] && port5WeakUp[3]) else $error("strong high drive too long");
  chk_sync_follow: assert property ((clockEnable && $stable(port3PinIn))[*5]
    |-> port3Pins == port3PinIn) else $error("sampled pins lag");
  chk_tx_override: assert property (serial0TxEnable |-> lvl3[1] == serial0Transmit)
    else $error("serial transmit not on pin");
  chk_data_strobes: assert property (extDataAccess
    |-> lvl3[7:6] == {dataReadStrobe_n, dataWriteStrobe_n}) else $error("strobes wrong");
  chk_addr_port2: assert property (extMemAccess |-> lvl2 == memAddrHigh[1:0])
    else $error("upper address bits wrong");
  chk_port4_memory: assert property (port4FunctionSelect != 8'h00
    |-> ((lvl4 ^ {memAddrHigh[5:2], programSelect}) & port4FunctionSelect) == 8'h00)
    else $error("port 4 memory signal wrong");
  chk_can_tx: assert property (canEnable |-> lvl5[0] == canTransmitOut)
    else $error("can transmit not on pin");
endmodule
bind quasi_bidir_port_altfunc quasi_port_asserts u_quasi_port_asserts (.*);

// file: tb/quasi_pin_world.sv
// Far-side circuits on a port: pull-up and optional external drivers
`timescale 1ns/100ps
module quasi_pin_world #(
  parameter int W = 8
) (
  // Device strong drive
  input  wire logic [W-1:0] pinOut,
  input  wire logic [W-1:0] pinOe,
  // External driver per pin
  input  wire logic [W-1:0] extEn,
  input  wire logic [W-1:0] extVal,
  // Resolved pin level
  output logic      [W-1:0] pinLevel
);
  // Strong drive wins; an external driver beats only the weak pull-up
  assign pinLevel = (pinOe & pinOut) | (~pinOe & (~extEn | extVal));
endmodule

// file: tb/tb.sv
// Self-checking bench for the quasi-bidirectional port block
`timescale 1ns/100ps
module tb;
  import quasi_port_pkg::*;
  logic       clock = 1'b0;
  logic       rst_n = 1'b0;
  logic       clockEnable = 1'b1;
  logic [3:0] portWrite = 4'h0;
  logic [7:0] writeData = 8'h00;
  logic [7:0] port4FunctionSelect = 8'h00;
  logic       extMemAccess = 1'b0, extDataAccess = 1'b0;
  logic [5:0] memAddrHigh = 6'h00;
  logic [3:0] programSelect = 4'h0;
  logic       dataWriteStrobe_n = 1'b1, dataReadStrobe_n = 1'b1;
  logic       serial0TxEnable = 1'b0, serial0Transmit = 1'b1;
  logic       clockOutEnable = 1'b0, clockOut = 1'b1;
  logic       canEnable = 1'b0, canTransmitOut = 1'b1;
  logic       serial0Receive, externalIrqZero, externalIrqOne, timerZeroCountInput;
  logic       timerOneInput, timerThreeExtInput, canReceiveIn;
  logic [1:0] port2PinIn, port2PinOut, port2PinOe, port2WeakUp, port2Pins, port2Latch;
  logic [7:0] port3PinIn, port3PinOut, port3PinOe, port3WeakUp, port3Pins, port3Latch;
  logic [7:0] port4PinIn, port4PinOut, port4PinOe, port4WeakUp, port4Pins, port4Latch;
  logic [7:0] port5PinIn, port5PinOut, port5PinOe, port5WeakUp, port5Pins, port5Latch;
  logic [7:0] extEn3 = 8'h00, extVal3 = 8'h00, extEn5 = 8'h00, extVal5 = 8'h00;
  int         checked = 0, n_mismatch = 0, cycles = 0;

  quasi_bidir_port_altfunc u_quasi_bidir_port_altfunc (.*);
  quasi_pin_world #(.W(2)) u_quasi_pin_world_p2 (.pinOut(port2PinOut), .pinOe(port2PinOe),
    .extEn(2'b00), .extVal(2'b00), .pinLevel(port2PinIn));
  quasi_pin_world u_quasi_pin_world_p3 (.pinOut(port3PinOut), .pinOe(port3PinOe),
    .extEn(extEn3), .extVal(extVal3), .pinLevel(port3PinIn));
  quasi_pin_world u_quasi_pin_world_p4 (.pinOut(port4PinOut), .pinOe(port4PinOe),
    .extEn(8'h00), .extVal(8'h00), .pinLevel(port4PinIn));
  quasi_pin_world u_quasi_pin_world_p5 (.pinOut(port5PinOut), .pinOe(port5PinOe),
    .extEn(extEn5), .extVal(extVal5), .pinLevel(port5PinIn));

  always #5 clock = ~clock;

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Whole run needs under 60 cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      n_mismatch++;
      test_done();
    end
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Inputs always move 1 ns after the edge
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic writePorts(input logic [3:0] which, input logic [7:0] data);
    portWrite = which;
    writeData = data;
    step(1);
    portWrite = 4'h0;
  endtask

  task automatic tReset();
    check("latches", port3Latch & port4Latch & port5Latch & {6'h3f, port2Latch}, 8'hff);
    check("drive off", port3PinOe | port4PinOe | port5PinOe | {6'h00, port2PinOe}, 8'h00);
    check("weak up", port3WeakUp & port4WeakUp & port5WeakUp & {6'h3f, port2WeakUp}, 8'hff);
  endtask

  task automatic tPullDown();
    writePorts(4'h8, 8'hff);
    check("no burst from one", port5PinOe, 8'h00);
    step(1);
    writePorts(4'hf, 8'h00);
    check("p5 low", port5PinIn, 8'h00);
    step(4);
    check("p3 held low", port3PinIn, 8'h00);
    check("p4 p2 sampled low", port4Pins | {6'h00, port2Pins}, 8'h00);
    check("p2 weak off", {6'h00, port2WeakUp}, 8'h00);
    writePorts(4'hf, 8'hff);
    check("p5 strong high", port5PinOe & port5PinOut, 8'hff);
    step(1);
    check("p4 strong high", port4PinOe, 8'hff);
    step(1);
    check("p5 released", port5PinOe | {6'h00, port2PinOe}, 8'h00);
    check("p5 weak up", port5WeakUp & port5PinIn, 8'hff);
  endtask

  task automatic tInputs();
    logic [7:0] v;
    for (int k = 0; k < 2; k++) begin
      v = k[0] ? 8'h5a : 8'ha5;
      extEn3 = 8'hff;
      extVal3 = v;
      extEn5 = 8'h06;
      extVal5 = v;
      step(5);
      check("p3 pins", port3Pins, v);
      check("p3 inputs", {3'h0, timerOneInput, timerZeroCountInput, externalIrqOne,
        externalIrqZero, serial0Receive}, {3'h0, v[5:2], v[0]});
      check("p5 inputs", {6'h00, timerThreeExtInput, canReceiveIn}, {6'h00, v[2:1]});
      check("p5 pins", port5Pins, 8'hf9 | (v & 8'h06));
    end
    extEn3 = 8'h00;
    extEn5 = 8'h00;
    step(5);
  endtask

  // Clock enable low: writes are lost and the synchroniser holds its value
  task automatic tFreeze();
    clockEnable = 1'b0;
    extEn3 = 8'hff;
    extVal3 = 8'h00;
    writePorts(4'h8, 8'h00);
    step(5);
    check("frozen latch", port5Latch, 8'hff);
    check("frozen pins", port3Pins, 8'hff);
    clockEnable = 1'b1;
    step(5);
    check("irq after thaw", {6'h00, externalIrqOne, externalIrqZero}, 8'h00);
    extEn3 = 8'h00;
    step(5);
  endtask

  // Latches at zero so every alternate value must override them
  task automatic tAltOut();
    logic [7:0] sel, e;
    writePorts(4'hf, 8'h00);
    {serial0TxEnable, clockOutEnable, canEnable, extMemAccess, extDataAccess} = 5'h1f;
    for (int k = 0; k < 2; k++) begin
      sel = k[0] ? 8'hf0 : 8'h0f;
      port4FunctionSelect = sel;
      {serial0Transmit, clockOut, canTransmitOut} = k[0] ? 3'b101 : 3'b010;
      {dataReadStrobe_n, dataWriteStrobe_n} = k[0] ? 2'b01 : 2'b10;
      memAddrHigh = k[0] ? 6'h2d : 6'h12;
      programSelect = k[0] ? 4'h6 : 4'h9;
      step(1);
      e = {dataReadStrobe_n, dataWriteStrobe_n, clockOut, 3'h0, serial0Transmit, 1'b0};
      check("p3 alt", port3PinIn, e);
      check("p2 addr", {6'h00, port2PinIn}, {6'h00, memAddrHigh[1:0]});
      check("p4 alt", port4PinIn, {memAddrHigh[5:2], programSelect} & sel);
      check("p5 can", port5PinIn, {7'h00, canTransmitOut});
    end
    {serial0TxEnable, clockOutEnable, canEnable, extMemAccess, extDataAccess} = 5'h00;
    port4FunctionSelect = 8'h00;
    step(1);
    check("latch back", port3PinIn | port4PinIn | {6'h00, port2PinIn}, 8'h00);
    writePorts(4'hf, 8'hff);
    step(3);
  endtask

  initial begin
    step(4);
    rst_n = 1'b1;
    step(1);
    tReset();
    tPullDown();
    tInputs();
    tFreeze();
    tAltOut();
    writePorts(4'hf, 8'h00);
    rst_n = 1'b0;
    step(2);
    rst_n = 1'b1;
    step(1);
    tReset();
    test_done();
  end
endmodule
